// *** hw/rfci_irq.v ***
// Summary of operation
// - measurement counter reaching 00000H halts both counters
// - reference done flag sets on first low-speed clock rise after ref run clears
// - time base counter reaching 00000H halts both counters
// - sensor done flag sets on first low-speed clock rise after sensor run clears
// - overflows end the conversion and set that phase's done flag too
// - interrupt request raised for a set flag whose mask bit is 1
// - mask bit 0 withholds the request even with the flag set
// - writing 1 to a flag clears it
// - writing 1 to ref run starts; device clears it at termination
// - writing 1 to sensor run with ref run 0 starts; device clears it at termination
// - overflow flags set on overflow; cleared on start or write of 1
`include "rfci_defines.vh"

module rfci_irq (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        ce,
  input  wire        lowSpeedOscClock,
  input  wire        measOscClock,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  output wire        irq
);

  // pin synchronisers, third stage only for edge detection
  reg  [2:0] oscSync_reg;
  reg  [2:0] measSync_reg;
  wire       oscRise;
  wire       measRise;

  always @(posedge mclk) begin
    if (!nrst) begin
      oscSync_reg  <= 3'h0;
      measSync_reg <= 3'h0;
    end else if (ce) begin
      oscSync_reg  <= {oscSync_reg[1:0], lowSpeedOscClock};
      measSync_reg <= {measSync_reg[1:0], measOscClock};
    end
  end

  assign oscRise  = oscSync_reg[1] && !oscSync_reg[2];
  assign measRise = measSync_reg[1] && !measSync_reg[2];

  // bus slave, zero wait states
  reg        dpValid_reg;
  reg        dpWrite_reg;
  reg  [7:0] dpAddr_reg;
  reg [31:0] rdata_reg;
  wire       apTake;
  wire       wrEn;

  assign apTake    = hsel && htrans[1] && hready;
  assign wrEn      = dpValid_reg && dpWrite_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  wire wrCtrl   = wrEn && (dpAddr_reg == `RFCI_ADDR_CTRL);
  wire wrStatus = wrEn && (dpAddr_reg == `RFCI_ADDR_STATUS);
  wire wrMask   = wrEn && (dpAddr_reg == `RFCI_ADDR_MASK);
  wire wrMeas   = wrEn && (dpAddr_reg == `RFCI_ADDR_MEAS);
  wire wrTb     = wrEn && (dpAddr_reg == `RFCI_ADDR_TIMEBASE);

  // conversion state
  reg                    refRun_reg;
  reg                    senseRun_reg;
  reg                    refPend_reg;
  reg                    sensePend_reg;
  reg  [`RFCI_ST_W-1:0]  status_reg;
  reg  [`RFCI_ST_W-1:0]  mask_reg;
  wire [`RFCI_CNT_W-1:0] measValue;
  wire [`RFCI_CNT_W-1:0] tbValue;
  wire                   measZero;
  wire                   tbZero;
  wire                   running;

  assign running = refRun_reg || senseRun_reg;

  wire startRef   = wrCtrl && !running && hwdata[`RFCI_CTRL_REF_RUN];
  wire startSense = wrCtrl && !running && !hwdata[`RFCI_CTRL_REF_RUN]
                    && hwdata[`RFCI_CTRL_SENSE_RUN];

  // counters step only while a conversion runs
  rfci_counter uMeas (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .load      (wrMeas),
    .loadValue (hwdata[`RFCI_CNT_W-1:0]),
    .step      (running && measRise),
    .countUp   (1'b1),
    .value     (measValue),
    .hitZero   (measZero)
  );

  rfci_counter uTimebase (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .load      (wrTb),
    .loadValue (hwdata[`RFCI_CNT_W-1:0]),
    .step      (running && oscRise),
    .countUp   (senseRun_reg),
    .value     (tbValue),
    .hitZero   (tbZero)
  );

  // termination conditions
  wire refEnd     = refRun_reg && (measZero || tbZero);
  wire senseEnd   = senseRun_reg && (measZero || tbZero);
  wire measOvfEvt = senseRun_reg && measZero;
  wire tbOvfEvt   = refRun_reg && tbZero;

  // done flags wait for the next low-speed clock rise after run clears
  wire refSet   = refPend_reg && oscRise;
  wire senseSet = sensePend_reg && oscRise;

  wire [`RFCI_ST_W-1:0] setVec;
  wire [`RFCI_ST_W-1:0] clrVec;
  wire [`RFCI_ST_W-1:0] startClr;

  assign setVec   = {tbOvfEvt, measOvfEvt, senseSet, refSet};
  assign startClr = (startRef || startSense) ? 4'hC : 4'h0;
  assign clrVec   = (wrStatus ? hwdata[`RFCI_ST_W-1:0] : 4'h0) | startClr;

  always @(posedge mclk) begin
    if (!nrst) begin
      refRun_reg    <= 1'b0;
      senseRun_reg  <= 1'b0;
      refPend_reg   <= 1'b0;
      sensePend_reg <= 1'b0;
      status_reg    <= `RFCI_RST_STATUS;
      mask_reg      <= `RFCI_RST_MASK;
    end else if (ce) begin
      if (startRef) begin
        refRun_reg <= 1'b1;
      end else if (refEnd) begin
        refRun_reg <= 1'b0;
      end
      if (startSense) begin
        senseRun_reg <= 1'b1;
      end else if (senseEnd) begin
        senseRun_reg <= 1'b0;
      end
      if (refEnd) begin
        refPend_reg <= 1'b1;
      end else if (refSet) begin
        refPend_reg <= 1'b0;
      end
      if (senseEnd) begin
        sensePend_reg <= 1'b1;
      end else if (senseSet) begin
        sensePend_reg <= 1'b0;
      end
      status_reg <= (status_reg & ~clrVec) | setVec;
      if (wrMask) begin
        mask_reg <= hwdata[`RFCI_ST_W-1:0];
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // address phase capture and read data
  reg [31:0] rdNext;

  always @* begin
    case (haddr[7:0])
      `RFCI_ADDR_CTRL:     rdNext = {30'h0, senseRun_reg, refRun_reg};
      `RFCI_ADDR_STATUS:   rdNext = {28'h0000000, status_reg};
      `RFCI_ADDR_MASK:     rdNext = {28'h0000000, mask_reg};
      `RFCI_ADDR_MEAS:     rdNext = {12'h000, measValue};
      `RFCI_ADDR_TIMEBASE: rdNext = {12'h000, tbValue};
      default:             rdNext = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      dpValid_reg <= 1'b0;
      dpWrite_reg <= 1'b0;
      dpAddr_reg  <= 8'h00;
      rdata_reg   <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        dpValid_reg <= apTake && (haddr[31:8] == 24'h000000);
        dpWrite_reg <= hwrite;
        dpAddr_reg  <= haddr[7:0];
      end
      if (apTake && !hwrite) begin
        rdata_reg <= (haddr[31:8] == 24'h000000) ? rdNext : 32'h00000000;
      end
    end
  end

endmodule // rfci_irq

// *** hw/rfci_defines.vh ***
`ifndef RFCI_DEFINES_VH
`define RFCI_DEFINES_VH

// register byte offsets
`define RFCI_ADDR_CTRL      8'h00
`define RFCI_ADDR_STATUS    8'h04
`define RFCI_ADDR_MASK      8'h08
`define RFCI_ADDR_MEAS      8'h0C
`define RFCI_ADDR_TIMEBASE  8'h10

// control fields
`define RFCI_CTRL_REF_RUN   0
`define RFCI_CTRL_SENSE_RUN 1

// status and mask fields
`define RFCI_ST_REF_DONE    0
`define RFCI_ST_SENSE_DONE  1
`define RFCI_ST_MEAS_OVF    2
`define RFCI_ST_TB_OVF      3
`define RFCI_ST_W           4

// counter width and zero value
`define RFCI_CNT_W          20
`define RFCI_CNT_ZERO       20'h00000

// reset values
`define RFCI_RST_STATUS     4'h0
`define RFCI_RST_MASK       4'h0
`define RFCI_RST_CNT        20'h00000

`endif

// *** hw/rfci_counter.v ***
`include "rfci_defines.vh"

// loadable 20-bit up/down counter, flags arrival at zero
module rfci_counter (
  input  wire                    mclk,
  input  wire                    nrst,
  input  wire                    ce,
  input  wire                    load,
  input  wire [`RFCI_CNT_W-1:0]  loadValue,
  input  wire                    step,
  input  wire                    countUp,
  output wire [`RFCI_CNT_W-1:0]  value,
  output wire                    hitZero
);

  reg  [`RFCI_CNT_W-1:0] cnt_reg;
  wire [`RFCI_CNT_W-1:0] cnt_next;

  assign cnt_next = countUp ? cnt_reg + 20'h00001 : cnt_reg - 20'h00001;
  assign hitZero  = step && !load && (cnt_next == `RFCI_CNT_ZERO);
  assign value    = cnt_reg;

  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg <= `RFCI_RST_CNT;
    end else if (ce) begin
      if (load) begin
        cnt_reg <= loadValue;
      end else if (step) begin
        cnt_reg <= cnt_next;
      end
    end
  end

endmodule // rfci_counter

// *** dv/rfci_irq_sva.sv ***
module rfci_irq_sva (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire take = hsel && htrans[1] && hready && ce;
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_irq_reset: assert property ($rose(nrst) |-> !irq) else $error("irq after reset");
  a_irq_clear: assert property ($fell(irq) && $past(nrst) |-> $past(take && hwrite, 2))
    else $error("irq fell without write");
  a_rdata_stands: assert property (!$stable(hrdata) && $past(nrst) |-> $past(take && !hwrite))
    else $error("hrdata moved without read");
  a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_freeze_irq: assert property (!ce |=> $stable(irq)) else $error("irq moved while frozen");
  a_upper_zero: assert property (hrdata[31:20] == 12'h000) else $error("upper read bits set");
  c_irq_rise: cover property ($rose(irq));
  c_unmapped: cover property (take && haddr[7:0] == 8'h14);
  c_freeze: cover property (!ce);
endmodule // rfci_irq_sva

bind rfci_irq rfci_irq_sva i_sva (.mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .irq(irq));

// *** dv/rfci_osc_model.sv ***
module rfci_osc_model (
  input wire logic  mclk,
  input wire logic  lsRun,
  input wire logic  msRun,
  output logic      lowSpeedOscClock = 1'b0,
  output logic      measOscClock = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  // both clocks stand low outside a run, half period of four mclk
  always @(posedge mclk) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      lowSpeedOscClock <= lsRun & ~lowSpeedOscClock;
      measOscClock <= msRun & ~measOscClock;
    end
  end
endmodule // rfci_osc_model

// *** dv/rfci_irq_tb.sv ***
module rfci_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, nrst = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        lsRun = 1'b0, msRun = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
  logic [4:0]  rows [4] = '{5'h00, 5'h03, 5'h04, 5'h07};
  wire         ls, ms, hreadyout, hresp, irq;
  wire  [31:0] hrdata;
  int          fail_count = 0, n_tests = 0;
  rfci_irq i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .lowSpeedOscClock(ls), .measOscClock(ms),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
  rfci_osc_model i_osc (.mclk(mclk), .lsRun(lsRun), .msRun(msRun), .lowSpeedOscClock(ls),
    .measOscClock(ms));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task ci(input logic e);
    @(posedge mclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // the far side runs its clocks for a span, then stands still
  task osc(input logic l, input logic m);
    lsRun <= l; msRun <= m;
    repeat (60) @(posedge mclk);
    lsRun <= 1'b0; msRun <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
  task wrap_up;
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1; ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    rd(8'h04, 32'h0); rd(8'h08, 32'h0); rd(8'h14, 32'h0); ci(1'b0);
    wr(8'h0C, 32'hFFFFE); wr(8'h10, 32'h0); wr(8'h08, 32'h1); wr(8'h00, 32'h1);
    osc(1'b0, 1'b1);
    rd(8'h00, 32'h0); rd(8'h0C, 32'h0);
    osc(1'b1, 1'b0);
    rd(8'h04, 32'h1); rd(8'h10, 32'h0);
    foreach (rows[i]) begin
      wr(8'h08, {28'h0, rows[i][4:1]}); ci(rows[i][0]);
    end
    wr(8'h04, 32'h0); rd(8'h04, 32'h1);
    wr(8'h04, 32'h1); rd(8'h04, 32'h0); ci(1'b0);
    wr(8'h0C, 32'h0); wr(8'h10, 32'hFFFFE); wr(8'h00, 32'h2);
    osc(1'b1, 1'b0);
    rd(8'h00, 32'h0); rd(8'h04, 32'h2); rd(8'h10, 32'h0); ci(1'b1);
    wr(8'h04, 32'h2); wr(8'h0C, 32'hFFFFF); wr(8'h10, 32'h0); wr(8'h00, 32'h2);
    osc(1'b0, 1'b1);
    rd(8'h04, 32'h4);
    osc(1'b1, 1'b0);
    rd(8'h04, 32'h6);
    wr(8'h00, 32'h1); rd(8'h04, 32'h2);
    wr(8'h10, 32'h1);
    osc(1'b1, 1'b0);
    rd(8'h04, 32'hB); rd(8'h00, 32'h0); ci(1'b1);
    wr(8'h04, 32'hF); rd(8'h04, 32'h0); ci(1'b0);
    wrap_up;
  end
endmodule // rfci_irq_tb
